// ===== dsc_cfg.svh
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
// ****************************************
// Mode register fields
// ****************************************
`define DSC_BL_LSB      0
`define DSC_BL_MSB      2
`define DSC_BT_BIT      3
`define DSC_CL_LSB      4
`define DSC_CL_MSB      6
`define DSC_TM_BIT      7
`define DSC_DLLRST_BIT  8
`define DSC_AP_BIT      8
`define DSC_DLLEN_BIT   0
`define DSC_DS0_BIT     1
`define DSC_DS1_BIT     6
// ****************************************
// Codes and timing
// ****************************************
`define DSC_BL2_CODE    3'h1
`define DSC_BL4_CODE    3'h2
`define DSC_BL8_CODE    3'h3
`define DSC_CL2_CODE    3'h2
`define DSC_CL3_CODE    3'h3
`define DSC_CL25_CODE   3'h6
`define DSC_MRS_CYCLES  2
`define DSC_DLL_CYCLES  200
`endif

// ===== dsc_pkg.sv
package dsc_pkg;
	typedef enum logic [2:0] {
		DSC_CMD_DESEL,
		DSC_CMD_NOP,
		DSC_CMD_MRS,
		DSC_CMD_EMRS,
		DSC_CMD_ACT,
		DSC_CMD_PRE,
		DSC_CMD_RD,
		DSC_CMD_WR
	} dsc_cmd_t;
	typedef enum logic [1:0] {
		DSC_IDLE,
		DSC_BUSY,
		DSC_DONE
	} dsc_mrs_st_t;
endpackage

// ===== dsc_burst_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_burst_seq
	import dsc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       start,
	input  wire logic [2:0] start_col,
	input  wire logic [3:0] blen,
	input  wire logic       interleave,
	output logic            active,
	output logic [2:0]      col,
	output logic            last
);
	logic [2:0] beat_q, beat_d;
	logic [2:0] base_q, base_d;
	logic [2:0] mask_q, mask_d;
	logic       type_q, type_d;
	logic       act_q, act_d;
	logic [2:0] col_d;
	// ****************************************
	// Burst column sequencer
	// ****************************************
	always_comb begin
		beat_d = beat_q;
		base_d = base_q;
		mask_d = mask_q;
		type_d = type_q;
		act_d  = act_q;
		if (start) begin
			beat_d = 3'h0;
			base_d = start_col;
			mask_d = 3'(blen - 4'h1);
			type_d = interleave;
			act_d  = 1'b1;
		end else if (act_q) begin
			beat_d = 3'(beat_q + 3'h1);
			if (beat_q == mask_q)
				act_d = 1'b0;
		end
		if (type_d)
			col_d = (base_d & ~mask_d) | ((base_d ^ beat_d) & mask_d);
		else
			col_d = (base_d & ~mask_d) |
				(3'(base_d + beat_d) & mask_d);
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			beat_q <= 3'h0;
			base_q <= 3'h0;
			mask_q <= 3'h0;
			type_q <= 1'b0;
			act_q  <= 1'b0;
			col    <= 3'h0;
			last   <= 1'b0;
		end else begin
			beat_q <= beat_d;
			base_q <= base_d;
			mask_q <= mask_d;
			type_q <= type_d;
			act_q  <= act_d;
			col    <= col_d;
			last   <= act_d && (beat_d == mask_d);
		end
	end
	assign active = act_q;
endmodule
`default_nettype wire

// ===== dsc_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_cmd_decode
	import dsc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [1:0]  ba,
	input  wire logic [11:0] addr,
	input  wire logic        self_refresh_exit,
	output logic [11:0]      mode_reg,
	output logic [13:0]      ext_mode_reg,
	output logic [3:0]       burst_len,
	output logic             burst_interleave,
	output logic [2:0]       cas_lat_x2,
	output logic             test_mode,
	output logic             mode_reserved,
	output logic             dll_reset,
	output logic             dll_enable,
	output logic [1:0]       drive_strength,
	output logic             mrs_busy,
	output logic [3:0]       bank_open,
	output logic             cmd_illegal,
	output logic             burst_active,
	output logic             burst_write,
	output logic [1:0]       burst_bank,
	output logic [2:0]       burst_col,
	output logic             burst_last,
	output logic [3:0]       rd_burst_len,
	output logic [2:0]       rd_cas_lat_x2
);
	// ****************************************
	// Decoding helpers
	// ****************************************
	// burst length code map
	function automatic logic [3:0] bl_decode(input logic [2:0] code);
		unique case (code)
			`DSC_BL2_CODE: bl_decode = 4'h2;
			`DSC_BL4_CODE: bl_decode = 4'h4;
			`DSC_BL8_CODE: bl_decode = 4'h8;
			default:       bl_decode = 4'h0;
		endcase
	endfunction
	function automatic logic [2:0] cl_decode(input logic [2:0] code);
		unique case (code)
			`DSC_CL2_CODE:  cl_decode = 3'h4;
			`DSC_CL25_CODE: cl_decode = 3'h5;
			`DSC_CL3_CODE:  cl_decode = 3'h6;
			default:        cl_decode = 3'h0;
		endcase
	endfunction
	function automatic dsc_cmd_t cmd_decode(input logic c, input logic r,
		input logic a, input logic w, input logic [1:0] b);
		dsc_cmd_t k;
		k = DSC_CMD_NOP;
		if (c)
			k = DSC_CMD_DESEL;
		else if (!r && !a && !w && b == 2'h0)
			k = DSC_CMD_MRS;
		else if (!r && !a && !w && b == 2'h1)
			k = DSC_CMD_EMRS;
		else if (!r && a && w)
			k = DSC_CMD_ACT;
		else if (!r && a && !w)
			k = DSC_CMD_PRE;
		else if (r && !a && w)
			k = DSC_CMD_RD;
		else if (r && !a && !w)
			k = DSC_CMD_WR;
		cmd_decode = k;
	endfunction
	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int PW = 20;
	logic [PW-1:0] s1_q, s2_q;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {self_refresh_exit, cke, cs_n, ras_n, cas_n, we_n,
				ba, addr};
			s2_q <= s1_q;
		end
	end
	logic        p_srx, p_cke, p_cs, p_ras, p_cas, p_we;
	logic [1:0]  p_ba;
	logic [11:0] p_a;
	assign {p_srx, p_cke, p_cs, p_ras, p_cas, p_we, p_ba, p_a} = s2_q;
	dsc_cmd_t cmd;
	assign cmd = p_cke ? cmd_decode(p_cs, p_ras, p_cas, p_we, p_ba)
		: DSC_CMD_DESEL;
	// ****************************************
	// Mode registers and banks
	// ****************************************
	dsc_mrs_st_t st_q, st_d;
	logic [11:0] mr_q, mr_d;
	logic [13:0] emr_q, emr_d;
	logic        dllen_q, dllen_d;
	logic        dllrst_q, dllrst_d;
	logic [3:0]  open_q, open_d;
	logic        ill_q, ill_d;
	logic        srx_q;
	always_comb begin
		st_d     = st_q;
		mr_d     = mr_q;
		emr_d    = emr_q;
		dllen_d  = dllen_q;
		dllrst_d = 1'b0;
		open_d   = open_q;
		ill_d    = 1'b0;
		unique case (st_q)
			DSC_IDLE: ;
			DSC_BUSY: st_d = DSC_DONE;
			DSC_DONE: st_d = DSC_IDLE;
		endcase
		if (st_q == DSC_BUSY && cmd != DSC_CMD_DESEL &&
			cmd != DSC_CMD_NOP)
			ill_d = 1'b1;
		else begin
			unique case (cmd)
				DSC_CMD_MRS: begin
					mr_d = p_a;
					st_d = DSC_BUSY;
					dllrst_d = p_a[`DSC_DLLRST_BIT];
				end
				DSC_CMD_EMRS: begin
					emr_d = {p_ba, p_a};
					st_d  = DSC_BUSY;
					dllen_d = p_a[`DSC_DLLEN_BIT];
				end
				DSC_CMD_ACT: open_d[p_ba] = 1'b1;
				DSC_CMD_PRE: begin
					if (p_a[`DSC_AP_BIT])
						open_d = 4'h0;
					else
						open_d[p_ba] = 1'b0;
				end
				default: ;
			endcase
		end
		if (p_srx && !srx_q)
			dllen_d = 1'b1;
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q     <= DSC_IDLE;
			mr_q     <= 12'h000;
			emr_q    <= 14'h0000;
			dllen_q  <= 1'b0;
			dllrst_q <= 1'b0;
			open_q   <= 4'h0;
			ill_q    <= 1'b0;
			srx_q    <= 1'b0;
		end else begin
			st_q     <= st_d;
			mr_q     <= mr_d;
			emr_q    <= emr_d;
			dllen_q  <= dllen_d;
			dllrst_q <= dllrst_d;
			open_q   <= open_d;
			ill_q    <= ill_d;
			srx_q    <= p_srx;
		end
	end
	// ****************************************
	// Decoded fields and burst launch
	// ****************************************
	// field decode
	assign burst_len        = bl_decode(mr_q[`DSC_BL_MSB:`DSC_BL_LSB]);
	assign burst_interleave = mr_q[`DSC_BT_BIT];
	assign cas_lat_x2       = cl_decode(mr_q[`DSC_CL_MSB:`DSC_CL_LSB]);
	assign test_mode        = mr_q[`DSC_TM_BIT];
	assign mode_reserved    = |mr_q[11:9];
	assign drive_strength   = {emr_q[`DSC_DS1_BIT], emr_q[`DSC_DS0_BIT]};
	assign mode_reg         = mr_q;
	assign ext_mode_reg     = emr_q;
	assign dll_enable       = dllen_q;
	assign dll_reset        = dllrst_q;
	assign bank_open        = open_q;
	assign cmd_illegal      = ill_q;
	assign mrs_busy         = st_q != DSC_IDLE;
	logic       go;
	logic       rw_q, rw_d;
	logic [1:0] bk_q, bk_d;
	logic [3:0] rbl_q, rbl_d;
	logic [2:0] rcl_q, rcl_d;
	assign go = (cmd == DSC_CMD_RD || cmd == DSC_CMD_WR) &&
		st_q != DSC_BUSY && burst_len != 4'h0;
	always_comb begin
		rw_d  = rw_q;
		bk_d  = bk_q;
		rbl_d = rbl_q;
		rcl_d = rcl_q;
		if (go) begin
			rw_d = cmd == DSC_CMD_WR;
			bk_d = p_ba;
			rbl_d = burst_len;
			rcl_d = cmd == DSC_CMD_RD ? cas_lat_x2 : rcl_q;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rw_q  <= 1'b0;
			bk_q  <= 2'h0;
			rbl_q <= 4'h0;
			rcl_q <= 3'h0;
		end else begin
			rw_q  <= rw_d;
			bk_q  <= bk_d;
			rbl_q <= rbl_d;
			rcl_q <= rcl_d;
		end
	end
	assign burst_write   = rw_q;
	assign burst_bank    = bk_q;
	assign rd_burst_len  = rbl_q;
	assign rd_cas_lat_x2 = rcl_q;
	dsc_burst_seq u_seq (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.start      (go),
		.start_col  (p_a[2:0]),
		.blen       (burst_len),
		.interleave (burst_interleave),
		.active     (burst_active),
		.col        (burst_col),
		.last       (burst_last)
	);
endmodule
`default_nettype wire

// ===== dsc_cmd_decode_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ******
// Checker
// ******
module dsc_chk
	import dsc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [1:0]  ba,
	input  wire logic [11:0] addr,
	input  wire logic [11:0] mode_reg,
	input  wire logic [13:0] ext_mode_reg,
	input  wire logic [3:0]  burst_len,
	input  wire logic        burst_interleave,
	input  wire logic [2:0]  cas_lat_x2,
	input  wire logic        dll_reset,
	input  wire logic [1:0]  drive_strength,
	input  wire logic        mrs_busy,
	input  wire logic [3:0]  bank_open,
	input  wire logic [2:0]  burst_col,
	input  wire logic [3:0]  rd_burst_len
);
	wire logic       sel = cke & ~cs_n;
	wire logic       ld  = sel & ~ras_n & ~cas_n & ~we_n & ~ba[1];
	wire logic       act = sel & ~ras_n & cas_n & we_n;
	wire logic       pre = sel & ~ras_n & cas_n & ~we_n;
	wire logic       rd  = sel & ras_n & ~cas_n & we_n;
	wire logic [3:0] bl_e = (mode_reg[2:0] == 3'h1) ? 4'h2 :
		(mode_reg[2:0] == 3'h2) ? 4'h4 : (mode_reg[2:0] == 3'h3) ? 4'h8 : 4'h0;
	wire logic [2:0] cl_e = (mode_reg[6:4] == 3'h2) ? 3'h4 :
		(mode_reg[6:4] == 3'h6) ? 3'h5 : (mode_reg[6:4] == 3'h3) ? 3'h6 : 3'h0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	AST_MRS_CAPTURE: assert property (ld && !ba[0] && !mrs_busy ##2 !mrs_busy
		|-> ##2 mode_reg == $past(addr, 4)) else $error("mode load wrong");
	AST_MRS_BUSY: assert property (ld && !mrs_busy ##2 !mrs_busy
		|-> ##1 mrs_busy[*2] ##1 (!mrs_busy || $past(ld, 3)))
		else $error("busy span wrong");
	AST_EMRS_CAPTURE: assert property (ld && ba[0] && !mrs_busy ##2 !mrs_busy
		|-> ##2 ext_mode_reg == {$past(ba, 4), $past(addr, 4)})
		else $error("ext load wrong");
	AST_DLL_RESET: assert property (ld && !ba[0] && addr[8] && !mrs_busy
		##2 !mrs_busy |-> ##1 dll_reset ##1 !dll_reset) else $error("dll reset");
	AST_FIELDS: assert property ($stable(mode_reg) |-> burst_len == bl_e
		&& cas_lat_x2 == cl_e && burst_interleave == mode_reg[3])
		else $error("mode fields wrong");
	AST_DRIVE: assert property ($stable(ext_mode_reg) |->
		drive_strength == {ext_mode_reg[6], ext_mode_reg[1]}) else $error("drive");
	AST_ACT_OPEN: assert property (act && !mrs_busy ##2 !mrs_busy
		|-> ##2 bank_open[$past(ba, 4)]) else $error("bank not opened");
	AST_PRE_CLOSE: assert property (pre && !mrs_busy ##2 !mrs_busy
		|-> ##2 ($past(addr[8], 4) ? bank_open == 4'h0 : !bank_open[$past(ba, 4)]))
		else $error("precharge wrong");
	AST_DESEL: assert property (cs_n[*4] |-> ##1 $stable(mode_reg)
		&& $stable(ext_mode_reg) && $stable(bank_open)) else $error("deselect");
	AST_RD_START: assert property (rd && burst_len != 4'h0 && !mrs_busy
		##2 !mrs_busy |-> ##1 burst_col == $past(addr[2:0], 3)
		&& rd_burst_len == $past(burst_len, 3)) else $error("read start");
endmodule
bind dsc_cmd_decode dsc_chk u_chk (.ref_clk(ref_clk), .resetn(resetn),
	.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.ba(ba), .addr(addr), .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg),
	.burst_len(burst_len), .burst_interleave(burst_interleave),
	.cas_lat_x2(cas_lat_x2), .dll_reset(dll_reset),
	.drive_strength(drive_strength), .mrs_busy(mrs_busy),
	.bank_open(bank_open), .burst_col(burst_col), .rd_burst_len(rd_burst_len));
`default_nettype wire

// ===== dsc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******
// Controller model
// ******
module dsc_ctl_model
	import dsc_pkg::*;
(
	input  wire logic        ref_clk,
	output logic             cke,
	output logic             cs_n,
	output logic             ras_n,
	output logic             cas_n,
	output logic             we_n,
	output logic [1:0]       ba,
	output logic [11:0]      addr
);
	initial begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		ba = 2'h0;
		addr = 12'h0;
	end
	task automatic issue(input dsc_cmd_t c, input logic [1:0] b,
		input logic [11:0] a);
		@(posedge ref_clk);
		#1;
		case (c)
			DSC_CMD_DESEL: {cs_n, ras_n, cas_n, we_n} = 4'h8;
			DSC_CMD_ACT:   {cs_n, ras_n, cas_n, we_n} = 4'h3;
			DSC_CMD_PRE:   {cs_n, ras_n, cas_n, we_n} = 4'h2;
			DSC_CMD_RD:    {cs_n, ras_n, cas_n, we_n} = 4'h5;
			DSC_CMD_WR:    {cs_n, ras_n, cas_n, we_n} = 4'h4;
			DSC_CMD_NOP:   {cs_n, ras_n, cas_n, we_n} = 4'h7;
			default:       {cs_n, ras_n, cas_n, we_n} = 4'h0;
		endcase
		ba = b;
		addr = a;
		@(posedge ref_clk);
		#1;
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		ba = ~b;
		addr = ~a;
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
// ******
// Testbench
// ******
module tb;
	import dsc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn, srx, cke, cs_n, ras_n, cas_n, we_n, it, busy, bwr;
	logic        dllen, bt, tm, rsv, ill, bact, blast;
	logic [1:0]  pb, drv, b, bbk;
	logic [11:0] pa, mode_reg, a, m;
	logic [13:0] ext;
	logic [3:0]  bl, open, rbl;
	logic [2:0]  cl, col, s, rcl;
	logic [2:0]  clc[3] = '{3'h2, 3'h3, 3'h6};
	logic [2:0]  clx[3] = '{3'h4, 3'h6, 3'h5};
	int          error_cnt = 0, cmp_count = 0, seed, bln, ill_cnt = 0;
	always #4 ref_clk = ~ref_clk;
	always @(negedge ref_clk)
		if (ill === 1'b1)
			ill_cnt++;
	dsc_ctl_model u_ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(pb), .addr(pa));
	dsc_cmd_decode u_dut (.ref_clk(ref_clk), .resetn(resetn), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(pb),
		.addr(pa), .self_refresh_exit(srx), .mode_reg(mode_reg),
		.ext_mode_reg(ext), .burst_len(bl), .burst_interleave(it),
		.cas_lat_x2(cl), .test_mode(tm), .mode_reserved(rsv), .dll_reset(),
		.dll_enable(dllen), .drive_strength(drv), .mrs_busy(busy),
		.bank_open(open), .cmd_illegal(ill), .burst_active(bact),
		.burst_write(bwr), .burst_bank(bbk), .burst_col(col),
		.burst_last(blast), .rd_burst_len(rbl), .rd_cas_lat_x2(rcl));
	function automatic logic [2:0] ecol(input logic [2:0] st, input int n,
		input logic il, input int j);
		logic [2:0] k;
		k = 3'(n - 1);
		return il ? ((st ^ 3'(j)) & k) | (st & ~k) : (3'(st + j) & k) | (st & ~k);
	endfunction
	task automatic chk(input string nm, input logic [15:0] sn, input logic [15:0] ex);
		cmp_count++;
		if (sn !== ex) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", nm, ex, sn);
		end
	endtask
	task automatic wt;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		test_done;
	end
	initial begin
		seed = 36379;
		resetn = 1'b0;
		srx = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("dll", 16'(dllen), 16'h0);
		srx = 1'b1;
		wt;
		chk("dll", 16'(dllen), 16'h1);
		a = 12'($random(seed)) & 12'h043;
		u_ctl.issue(DSC_CMD_EMRS, 2'h1, a);
		wt;
		chk("ext", 16'(ext), 16'({2'h1, a}));
		chk("drv", 16'(drv), 16'({a[6], a[1]}));
		chk("dllen", 16'(dllen), 16'(a[0]));
		repeat (`DSC_DLL_CYCLES) @(posedge ref_clk);
		for (int i = 0; i < 9; i++) begin
			bln = 2 << (i % 3);
			bt = 1'($random(seed));
			a = {3'h0, 1'($random(seed)), 1'b0, clc[i / 3], bt, 3'(i % 3 + 1)};
			u_ctl.issue(DSC_CMD_MRS, 2'h0, a);
			repeat (3) @(posedge ref_clk);
			#1 chk("busy", 16'(busy), 16'h1);
			wt;
			chk("mode", 16'(mode_reg), 16'(a));
			chk("bl", 16'(bl), 16'(bln));
			chk("cl", 16'(cl), 16'(clx[i / 3]));
			chk("bt", 16'(it), 16'(bt));
			chk("tm", 16'(tm), 16'h0);
			chk("rsv", 16'(rsv), 16'h0);
			b = 2'($random(seed));
			u_ctl.issue(DSC_CMD_ACT, b, 12'($random(seed)));
			wt;
			chk("open", 16'(open[b]), 16'h1);
			s = 3'($random(seed));
			u_ctl.issue(DSC_CMD_RD, b, {4'h0, 5'($random(seed)), s});
			repeat (2) @(posedge ref_clk);
			for (int j = 0; j < bln; j++) begin
				#1 chk("col", 16'(col), 16'(ecol(s, bln, bt, j)));
				chk("last", 16'(blast), 16'(j == bln - 1));
				chk("act", 16'(bact), 16'h1);
				@(posedge ref_clk);
			end
			#1 chk("rlen", 16'(rbl), 16'(bln));
			chk("rcl", 16'(rcl), 16'(clx[i / 3]));
			chk("idle", 16'(bact), 16'h0);
			chk("bank", 16'(bbk), 16'(b));
			u_ctl.issue(DSC_CMD_WR, b, {4'h0, 8'($random(seed))});
			wt;
			chk("wr", 16'(bwr), 16'h1);
			chk("wlen", 16'(rbl), 16'(bln));
			u_ctl.issue(DSC_CMD_PRE, b, 12'h0);
			wt;
			chk("pre", 16'(open[b]), 16'h0);
		end
		m = mode_reg;
		u_ctl.issue(DSC_CMD_DESEL, 2'h0, ~m);
		wt;
		chk("desel", 16'(mode_reg), 16'(m));
		u_ctl.issue(DSC_CMD_MRS, 2'h0, m);
		for (int k = 0; k < 4; k++)
			u_ctl.issue(DSC_CMD_ACT, 2'(k), 12'($random(seed)));
		wt;
		chk("all", 16'(open), 16'hf);
		u_ctl.issue(DSC_CMD_PRE, 2'($random(seed)), 12'h100);
		wt;
		chk("preall", 16'(open), 16'h0);
		chk("ill", 16'(ill_cnt), 16'h0);
		test_done;
	end
endmodule
`default_nettype wire
